/* File: logic/scan_pkg.sv */
// constants shared by the register preload and observe scan path
package scan_pkg;
    // ********************************************************
    // chain geometry
    // ********************************************************
    localparam int NUM_REGS      = 128;  // registers in the chain
    localparam int NUM_BURIED    = 24;   // buried registers
    localparam int QUAD_LEN      = 32;   // chain positions per quadrant
    localparam int BURIED_PER_Q  = 6;
    localparam int BURIED_FIRST  = 2;    // first buried slot in a quadrant
    localparam int BURIED_STRIDE = 5;    // slots between buried registers
    localparam logic [127:0] REGS_RESET = 128'h0;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int SYS_CLK_PERIOD_NS         = 4;
    localparam int POWER_UP_CLEAR_TIME_NS    = 1000; // longest clear time
    localparam int POWER_UP_CLEAR_TYP_NS     = 600;
    // longest time rounds down, never below one cycle
    localparam int CLEAR_CYCLES = (POWER_UP_CLEAR_TIME_NS / SYS_CLK_PERIOD_NS
                                   < 1) ? 1 :
                                  POWER_UP_CLEAR_TIME_NS / SYS_CLK_PERIOD_NS;
    localparam logic [8:0] CLEAR_CNT_RESET = 9'h000;

    // chain position of buried register b (highest index nearest input)
    function automatic int buried_pos(input int b);
        int k;
        k = (NUM_BURIED - 1) - b;
        return (k / BURIED_PER_Q) * QUAD_LEN + BURIED_FIRST
               + (k % BURIED_PER_Q) * BURIED_STRIDE;
    endfunction
endpackage

/* File: logic/scan_preload_observe.sv */
// serial preload/observe scan path with power-up register clear
`timescale 1ns/1ps
module scan_preload_observe #(
    parameter int NUM_REGS   = scan_pkg::NUM_REGS,
    parameter int NUM_BURIED = scan_pkg::NUM_BURIED
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  ce_i,
    input  wire logic                  scan_clk_i,
    input  wire logic                  scan_entry_i,
    input  wire logic                  scan_din_i,
    input  wire logic                  scan_oe_i,
    input  wire logic                  capt_en_i,
    input  wire logic [NUM_REGS-1:0]   capt_d_i,
    input  wire logic [NUM_REGS-1:0]   pol_inv_i,
    output logic                       scan_dout_o,
    output logic                       scan_dout_oe_n_o,
    output logic                       scan_active_o,
    output logic                       ready_o,
    output logic [NUM_REGS-1:0]        reg_q_o,
    output logic [NUM_REGS-1:0]        pin_o,
    output logic [NUM_BURIED-1:0]      buried_q_o
);
    // ********************************************************
    // scan clock domain
    // ********************************************************
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic din_cap_ff;
    logic tog_ff;

    // reset brought into the scan domain; takes effect only on scan clock edges
    always_ff @(posedge scan_clk_i)
    begin
        rst_s1_ff <= nrst_i;
        rst_s2_ff <= rst_s1_ff;
    end

    // capture the serial bit and flag the pulse with a toggle
    always_ff @(posedge scan_clk_i)
    begin
        if (!rst_s2_ff)
        begin
            din_cap_ff <= 1'b0;
            tog_ff     <= 1'b0;
        end
        else
        begin
            din_cap_ff <= scan_din_i;
            tog_ff     <= ~tog_ff;
        end
    end

    // ********************************************************
    // synchronisers into the system domain
    // ********************************************************
    logic ent_s1_ff;
    logic ent_s2_ff;
    logic oe_s1_ff;
    logic oe_s2_ff;
    logic tog_s1_ff;
    logic tog_s2_ff;
    logic tog_seen_ff;
    logic scan_ff;
    logic shift;

    // ce freezes the system domain only; scan domain runs on its own clock
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            ent_s1_ff <= 1'b0;
            ent_s2_ff <= 1'b0;
            oe_s1_ff  <= 1'b0;
            oe_s2_ff  <= 1'b0;
            tog_s1_ff <= 1'b0;
            tog_s2_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            ent_s1_ff <= scan_entry_i;
            ent_s2_ff <= ent_s1_ff;
            oe_s1_ff  <= scan_oe_i;
            oe_s2_ff  <= oe_s1_ff;
            tog_s1_ff <= tog_ff;
            tog_s2_ff <= tog_s1_ff;
        end
    end

    // pulses before entry are absorbed, so none shift at entry
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            tog_seen_ff <= 1'b0;
            scan_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            tog_seen_ff <= tog_s2_ff;
            scan_ff     <= ent_s2_ff;
        end
    end

    // captured bit is settled long before its toggle gets through
    assign shift = scan_ff && (tog_s2_ff != tog_seen_ff);

    // ********************************************************
    // power-up clear window
    // ********************************************************
    logic [8:0] clr_cnt_ff;
    logic       ready_ff;

    // normal capture held off until the clear interval has passed; scan shifts are not
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            clr_cnt_ff <= scan_pkg::CLEAR_CNT_RESET;
            ready_ff   <= 1'b0;
        end
        else if (ce_i && !ready_ff)
        begin
            clr_cnt_ff <= clr_cnt_ff + 9'h001;
            ready_ff   <= (clr_cnt_ff == 9'(scan_pkg::CLEAR_CYCLES - 1));
        end
    end

    // ********************************************************
    // device registers and scan chain
    // ********************************************************
    logic [NUM_REGS-1:0] reg_ff;

    // position 0 sits next to serial in, top position feeds serial out
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            reg_ff <= scan_pkg::REGS_RESET;
        else if (ce_i)
        begin
            if (shift)
                reg_ff <= {reg_ff[NUM_REGS-2:0], din_cap_ff};
            else if (!scan_ff && ready_ff && capt_en_i)
                reg_ff <= capt_d_i; // normal clocking resumes
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    logic [NUM_BURIED-1:0] nxt_buried;

    // buried registers picked from their chain slots, descending
    always_comb
    begin
        for (int b = 0; b < NUM_BURIED; b++)
            nxt_buried[b] = reg_ff[scan_pkg::buried_pos(b)];
    end

    // every output re-timed so it leaves straight from a flop
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            scan_dout_o      <= 1'b0;
            scan_dout_oe_n_o <= 1'b1;
            scan_active_o    <= 1'b0;
            ready_o          <= 1'b0;
            reg_q_o          <= scan_pkg::REGS_RESET;
            pin_o            <= scan_pkg::REGS_RESET;
            buried_q_o       <= '0;
        end
        else if (ce_i)
        begin
            scan_dout_o      <= reg_ff[NUM_REGS-1];
            scan_dout_oe_n_o <= !scan_ff || oe_s2_ff;
            scan_active_o    <= scan_ff;
            ready_o          <= ready_ff;
            reg_q_o          <= reg_ff;
            pin_o            <= reg_ff ^ pol_inv_i;
            buried_q_o       <= nxt_buried;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    chk_chain_shift_moves: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i && shift |=>
        reg_ff[NUM_REGS-1:1] == $past(reg_ff[NUM_REGS-2:0]))
        else $error("chain did not move one place");

    chk_raw_bit_load: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i && shift |=> reg_ff[0] == $past(din_cap_ff))
        else $error("scanned bit not loaded raw");

    chk_dout_tail_bit: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i && shift ##1 ce_i |=>
        scan_dout_o == $past(reg_ff[NUM_REGS-2], 2))
        else $error("serial out not showing chain tail");

    chk_dout_float_oe: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i && scan_ff && oe_s2_ff |=> scan_dout_oe_n_o)
        else $error("serial out driven while output enable high");

    chk_clear_all_low: assert property (@(posedge sys_clk_i)
        !nrst_i |=> reg_ff == scan_pkg::REGS_RESET && !ready_o)
        else $error("power-up clear left a register set");

    chk_pin_polarity_map: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i |=> pin_o == $past(reg_ff ^ pol_inv_i))
        else $error("pin level ignores output polarity");

    chk_clear_window_held: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ready_ff |->
        clr_cnt_ff == 9'(scan_pkg::CLEAR_CYCLES))
        else $error("clear interval length wrong");

    chk_keep_after_exit: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i && !shift && !(capt_en_i && ready_ff
        && !scan_ff) |=> reg_ff == $past(reg_ff))
        else $error("registers changed without shift or capture");

    chk_buried_order: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i |=> buried_q_o[NUM_BURIED-1] ==
        $past(reg_ff[2]) && buried_q_o[0] == $past(reg_ff[NUM_REGS-5]))
        else $error("buried register order wrong");

    chk_no_capture_scan: assert property (@(posedge sys_clk_i)
        disable iff (!nrst_i) ce_i && scan_ff && !shift |=>
        reg_ff == $past(reg_ff))
        else $error("normal capture disturbed scan state");
endmodule // scan_preload_observe

/* File: test/scan_tester.sv */
// tester model driving scan entry, scan clock, serial data and enable
`timescale 1ns/1ps
module scan_tester (
    input  wire logic scan_dout_i,
    output logic      scan_clk_o,
    output logic      scan_entry_o,
    output logic      scan_din_o,
    output logic      scan_oe_o
);
    // scan clock parked low so raising entry never shifts
    initial
    begin
        scan_clk_o   = 1'h0;
        scan_entry_o = 1'h0;
        scan_din_o   = 1'h0;
        scan_oe_o    = 1'h0;
    end

    // entry held for the session, moved only with clocks low
    task automatic level(input logic entry, input logic oe);
        #1.3;
        scan_entry_o = entry;
        scan_oe_o    = oe;
    endtask

    // one shift; loop feeds serial out back in to observe only
    task automatic pulse(input logic bit_v, input logic loop);
        #1.3;
        scan_din_o = loop ? scan_dout_i : bit_v;
        #31.0;
        scan_clk_o = 1'h1;
        #32.0;
        scan_clk_o = 1'h0;
        // hold over: show a moving level, never the stale bit
        scan_din_o = ~scan_din_o;
    endtask
endmodule // scan_tester

/* File: test/register_preload_observe_scan_tb_top.sv */
// self-checking bench for the preload and observe scan path
`timescale 1ns/1ps
module register_preload_observe_scan_tb_top;
    logic         sys_clk_i, nrst_i, capt_en_i;
    logic         scan_clk_i, scan_entry_i, scan_din_i, scan_oe_i;
    logic         scan_dout_o, scan_dout_oe_n_o, scan_active_o, ready_o;
    logic [127:0] capt_d_i, pol_inv_i, reg_q_o, pin_o, model, v, saved;
    logic [23:0]  buried_q_o;
    logic [7:0]   seed = 8'h57;
    int           err_total = 0;
    int           samples_checked = 0;
    int           n;

    scan_preload_observe u_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(1'h1),
        .scan_clk_i(scan_clk_i), .scan_entry_i(scan_entry_i),
        .scan_din_i(scan_din_i), .scan_oe_i(scan_oe_i),
        .capt_en_i(capt_en_i), .capt_d_i(capt_d_i), .pol_inv_i(pol_inv_i),
        .scan_dout_o(scan_dout_o), .scan_dout_oe_n_o(scan_dout_oe_n_o),
        .scan_active_o(scan_active_o), .ready_o(ready_o),
        .reg_q_o(reg_q_o), .pin_o(pin_o), .buried_q_o(buried_q_o));
    scan_tester u_tester (
        .scan_dout_i(scan_dout_o), .scan_clk_o(scan_clk_i),
        .scan_entry_o(scan_entry_i), .scan_din_o(scan_din_i),
        .scan_oe_o(scan_oe_i));

    // ********************
    // helpers
    // ********************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic rnd(output logic [127:0] r);
        for (int i = 0; i < 128; i++)
        begin
            seed = lfsr(seed);
            r[i] = seed[0];
        end
    endtask
    task automatic chk(input string nm, input logic [127:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // normal capture, register clock low again before any scan
    task automatic capture;
        rnd(v);
        @(posedge sys_clk_i);
        capt_d_i  <= v;
        capt_en_i <= 1'h1;
        @(posedge sys_clk_i);
        capt_en_i <= 1'h0;
        model = v;
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk("capture", reg_q_o, model);
        chk("pins", pin_o, model ^ pol_inv_i);
    endtask
    // shift cnt bits, recirculating the tail when loop is set
    task automatic burst(input int cnt, input logic loop, input logic oe);
        rnd(v);
        for (int i = 0; i < cnt; i++)
        begin
            u_tester.pulse(v[i], loop);
            model = {model[126:0], loop ? model[127] : v[i]};
            chk("chain", reg_q_o, model);
            chk("float", scan_dout_oe_n_o, oe);
            if (!oe)
                chk("serial_out", scan_dout_o, model[127]);
        end
    endtask

    initial
    begin
        sys_clk_i = 1'h0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // ********************
    // main sequence
    // ********************
    initial
    begin
        nrst_i    <= 1'h0;
        capt_en_i <= 1'h0;
        capt_d_i  <= 128'h0;
        rnd(v);
        pol_inv_i <= v;
        // scan-side flops clear only if the scan clock runs in reset
        repeat (3) u_tester.pulse(1'h0, 1'h0);
        @(posedge sys_clk_i);
        nrst_i <= 1'h1;
        #1;
        chk("reset_outs", {scan_dout_oe_n_o, scan_active_o, ready_o}, 3'h4);
        n = 0;
        // scan clock held still until the clear has run out
        while (ready_o !== 1'h1 && n < 400)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("clear_time", n, scan_pkg::CLEAR_CYCLES + 1);
        if (n >= 400)
            tally_and_finish();
        #1;
        chk("cleared", reg_q_o, 128'h0);
        chk("pins", pin_o, pol_inv_i);
        $display("test power_up done");
        capture();
        // scan-side reset lets go only after two more scan clock edges
        repeat (2) u_tester.pulse(1'h0, 1'h0);
        u_tester.level(1'h1, 1'h0);
        repeat (8) @(posedge sys_clk_i);
        burst(128, 1'h0, 1'h0);
        for (int b = 0; b < 24; b++)
            chk("buried", buried_q_o[b], model[((23 - b) / 6) * 32 + 2
                + ((23 - b) % 6) * 5]);
        $display("test preload done");
        saved = model;
        burst(128, 1'h1, 1'h0);
        chk("restored", reg_q_o, saved);
        u_tester.level(1'h1, 1'h1);
        repeat (8) @(posedge sys_clk_i);
        burst(6, 1'h0, 1'h1);
        repeat (8) @(posedge sys_clk_i);
        u_tester.level(1'h0, 1'h0);
        repeat (8) @(posedge sys_clk_i);
        #1;
        chk("active", scan_active_o, 1'h0);
        chk("kept", reg_q_o, model);
        capture();
        $display("test exit done");
        tally_and_finish();
    end
endmodule // register_preload_observe_scan_tb_top
